// *** rtl/usr_pkg.sv ***
// Constants and types for the endpoint status reporting block
package usr_pkg;

  // Command codes and command groups
  localparam logic [7:0] CMD_IRQ_READ = 8'hf4;
  localparam logic [7:0] CMD_BUF_IRQ_MODE = 8'hec;
  localparam logic [3:0] GRP_SELECT = 4'h0;
  localparam logic [3:0] GRP_LAST_STATUS = 4'h4;
  localparam logic [3:0] GRP_BUF_STATUS = 4'h8;

  // Endpoint index counts per command set
  localparam logic [4:0] DEF_INDEX_COUNT = 5'h06;
  localparam logic [4:0] ENH_INDEX_COUNT = 5'h10;

  // Interrupt byte counts
  localparam logic [2:0] IRQ_BYTES_DEF = 3'h2;
  localparam logic [2:0] IRQ_BYTES_ENH = 3'h4;

  // Bit positions
  localparam int IRQ_BUS_RESET_BIT = 6;
  localparam int IRQ_SUSPEND_BIT = 7;
  localparam int IRQ_DMA_BIT = 0;
  localparam int SEL_FULL_BIT = 0;
  localparam int SEL_STALL_BIT = 1;
  localparam int LTS_PREV_BIT = 7;
  localparam int LTS_SETUP_BIT = 5;
  localparam int BUF_SETUP_BIT = 2;
  localparam int BUF_FULL0_BIT = 5;
  localparam int BUF_FULL1_BIT = 6;
  localparam int BUF_STALL_BIT = 7;

  // Reset values and counts
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] SUSPEND_MISS_COUNT = 2'h3;

  // Transaction error codes
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_PID_ENCODING = 4'h1;
  localparam logic [3:0] ERR_PID_UNKNOWN = 4'h2;
  localparam logic [3:0] ERR_UNEXPECTED_PKT = 4'h3;
  localparam logic [3:0] ERR_TOKEN_CRC = 4'h4;
  localparam logic [3:0] ERR_DATA_CRC = 4'h5;
  localparam logic [3:0] ERR_TIMEOUT = 4'h6;
  localparam logic [3:0] ERR_UNEXPECTED_EOP = 4'h8;
  localparam logic [3:0] ERR_NAKED = 4'h9;
  localparam logic [3:0] ERR_SENT_STALL = 4'ha;
  localparam logic [3:0] ERR_BUF_OVERFLOW = 4'hb;
  localparam logic [3:0] ERR_BIT_STUFF = 4'hd;
  localparam logic [3:0] ERR_WRONG_DATA_PID = 4'hf;

  // Read sequence states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_IRQ = 5'b00010,
    ST_SEL = 5'b00100,
    ST_LTS = 5'b01000,
    ST_BUF = 5'b10000
  } usr_state_type;

endpackage : usr_pkg

// *** rtl/usr_suspend_detect.sv ***
// Suspend detector counting frames without start-of-frame
`timescale 1ns/1ps
module usr_suspend_detect
  import usr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Frame events
  input wire logic sof_seen,
  input wire logic frame_tick,
  // State
  output logic suspended,
  output logic change
);

  typedef struct packed {
    logic got_sof;
    logic [1:0] miss;
    logic suspended;
    logic change;
  } usr_susp_type;

  usr_susp_type s;
  usr_susp_type next_s;

  // R5 missed frame count
  always_comb
  begin
    next_s = s;
    next_s.change = 1'b0;
    if (sof_seen)
    begin
      next_s.got_sof = 1'b1;
      next_s.miss = 2'h0;
      if (s.suspended)
      begin
        next_s.suspended = 1'b0;
        next_s.change = 1'b1;
      end
    end
    if (frame_tick && !sof_seen)
    begin
      next_s.got_sof = 1'b0;
      if (s.got_sof)
        next_s.miss = 2'h0;
      else if (!s.suspended)
      begin
        if (s.miss == SUSPEND_MISS_COUNT - 2'h1)
        begin
          next_s.suspended = 1'b1;
          next_s.change = 1'b1;
          next_s.miss = 2'h0;
        end
        else
          next_s.miss = s.miss + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s <= '0;
    else if (ce)
      s <= next_s;
  end

  assign suspended = s.suspended;
  assign change = s.change;

endmodule : usr_suspend_detect

// *** rtl/usr_status_store.sv ***
// Last transaction status store, one entry per endpoint index
`timescale 1ns/1ps
module usr_status_store
  import usr_pkg::*;
#(
  parameter int ENTRIES = 16
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Status write from the engine
  input wire logic wr_en,
  input wire logic [3:0] wr_index,
  input wire logic [6:0] wr_status,
  // Host read
  input wire logic rd_clear,
  input wire logic [3:0] rd_index,
  output logic [7:0] rd_byte,
  output logic [ENTRIES-1:0] setup_bits
);

  typedef struct packed {
    logic [ENTRIES-1:0][6:0] status;
    logic [ENTRIES-1:0] unread;
    logic [ENTRIES-1:0] overwritten;
  } usr_store_type;

  usr_store_type s;
  usr_store_type next_s;
  logic [ENTRIES-1:0] wr_hit;
  logic [ENTRIES-1:0] rd_hit;

  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi++)
    begin : g_entry
      assign wr_hit[gi] = wr_en && (wr_index == 4'(gi));
      assign rd_hit[gi] = rd_clear && (rd_index == 4'(gi));
      assign setup_bits[gi] = s.status[gi][LTS_SETUP_BIT];
    end
  endgenerate

  always_comb
  begin
    next_s = s;
    for (int i = 0; i < ENTRIES; i++)
    begin
      if (rd_hit[i])
      begin
        next_s.unread[i] = 1'b0;
        next_s.overwritten[i] = 1'b0;
      end
      if (wr_hit[i])
      begin
        // R15 error code stored unchanged
        next_s.status[i] = wr_status;
        next_s.unread[i] = 1'b1;
        // R14 unread status overwritten
        next_s.overwritten[i] = (s.unread[i] && !rd_hit[i]) || (s.overwritten[i] && !rd_hit[i]);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s <= '0;
    else if (ce)
      s <= next_s;
  end

  // R12 R13 status byte layout
  assign rd_byte = {s.overwritten[rd_index], s.status[rd_index]};

endmodule : usr_status_store

// *** rtl/usr_status_top.sv ***
// Command-addressed endpoint status and interrupt reporting
// Contract
// R1 - Interrupt read gives up to two bytes default, four enhanced, in order.
// R2 - First interrupt byte bits 0-5 are endpoint 0-2 OUT/IN flags, reset zero.
// R3 - Endpoint flag stays set until its last transaction status is read.
// R4 - Bit 6 of first byte flags bus reset, cleared when read.
// R5 - Bit 7 flags suspend entry after three missed frames or resume, read clears.
// R6 - Second byte bit 0 flags DMA done, read clears; upper bits reserved.
// R7 - Enhanced third byte holds endpoint 3-6 OUT/IN flags.
// R8 - Enhanced fourth byte holds endpoint 7 OUT/IN flags; bits 7-2 reserved.
// R9 - Select command takes six or sixteen index codes; one status byte readable.
// R10 - Select status: bit 0 buffer full, bit 1 stalled, rest reserved.
// R11 - Last status command per index returns exactly one byte.
// R12 - Status bit 0 success, bits 4-1 four-bit error code.
// R13 - Status bit 5 after SETUP, bit 6 data toggle of packet.
// R14 - Status bit 7 set when an unread earlier status was overwritten.
// R15 - Error codes follow the fixed transaction error encoding.
// R16 - Buffer status command per index returns byte with SETUP at bit 2.
// R17 - Buffer status bits 5 and 6 show each packet buffer full.
// R18 - Buffer status bit 7 shows stall; bits 1-0 and 4-3 reserved.
// R19 - Active-low interrupt output asserted while any interrupt flag is set.
// R20 - Interrupt read primes buffer resume after two bytes, or four once enabled.
// R21 - Short interrupt reads clear only flags in bytes actually transferred.
// R22 - A flag set in the cycle it is read stays set.
`timescale 1ns/1ps
module usr_status_top
  import usr_pkg::*;
#(
  parameter int INDEX_COUNT = 16
)
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic CE,
  // Command port
  input wire logic CMD_WR,
  input wire logic [7:0] CMD_CODE,
  input wire logic DATA_RD,
  output logic [7:0] DATA_OUT,
  output logic DATA_VALID,
  // Mode
  input wire logic ENHANCED,
  // Transaction engine events
  input wire logic XFER_DONE,
  input wire logic [3:0] XFER_INDEX,
  input wire logic [6:0] XFER_STATUS,
  input wire logic BUS_RESET_SEEN,
  input wire logic SOF_SEEN,
  input wire logic FRAME_TICK,
  input wire logic TRANSFER_END_STROBE,
  // Endpoint buffer state
  input wire logic [INDEX_COUNT-1:0] BUF0_FULL,
  input wire logic [INDEX_COUNT-1:0] BUF1_FULL,
  input wire logic [INDEX_COUNT-1:0] EP_STALLED,
  input wire logic BUF_XFER_OPEN,
  // Status outputs
  output logic INT_N,
  output logic SUSPENDED,
  output logic BUF_RESUME
);

  typedef struct packed {
    usr_state_type state;
    logic [2:0] byte_cnt;
    logic [3:0] index;
    logic [3:0] sel_index;
    logic prime4;
    logic [INDEX_COUNT-1:0] ep_flag;
    logic bus_reset_flag;
    logic suspend_flag;
    logic dma_done_flag;
    logic [7:0] data_out;
    logic data_valid;
    logic int_n;
    logic suspended;
    logic resume;
  } usr_top_type;

  usr_top_type s;
  usr_top_type next_s;

  logic susp_level;
  logic susp_change;
  logic [7:0] lts_byte;
  logic [INDEX_COUNT-1:0] setup_bits;
  logic lts_clear;
  logic [3:0] lts_index;
  logic consume;
  logic [3:0] cmd_index;
  logic cmd_index_ok;
  logic xfer_index_ok;
  logic [4:0] index_count;

  usr_suspend_detect u_suspend (
    .clk(REF_CLK),
    .rstn(RSTN),
    .ce(CE),
    .sof_seen(SOF_SEEN),
    .frame_tick(FRAME_TICK),
    .suspended(susp_level),
    .change(susp_change)
  );

  usr_status_store #(
    .ENTRIES(INDEX_COUNT)
  ) u_store (
    .clk(REF_CLK),
    .rstn(RSTN),
    .ce(CE),
    .wr_en(XFER_DONE && xfer_index_ok),
    .wr_index(XFER_INDEX),
    // R12 R13 R15 status kept as coded
    .wr_status(XFER_STATUS),
    .rd_clear(lts_clear),
    .rd_index(lts_index),
    .rd_byte(lts_byte),
    .setup_bits(setup_bits)
  );

  // R9 R11 R16 index range per mode
  assign index_count = ENHANCED ? ENH_INDEX_COUNT : DEF_INDEX_COUNT;
  assign cmd_index = CMD_CODE[3:0];
  assign cmd_index_ok = {1'b0, cmd_index} < index_count;
  assign xfer_index_ok = {1'b0, XFER_INDEX} < index_count;
  assign consume = DATA_RD && s.data_valid && !CMD_WR;
  // R3 R11 one byte read clears entry
  assign lts_clear = consume && (s.state == ST_LTS);
  assign lts_index = CMD_WR ? cmd_index : s.index;

  // R2 R4 R5 R6 R7 R8 interrupt byte layout
  function automatic logic [7:0] irq_byte(
    input logic [2:0] cnt,
    input logic [INDEX_COUNT-1:0] ep,
    input logic br,
    input logic sp,
    input logic dm
  );
    logic [7:0] b;
    b = BYTE_RESET;
    case (cnt)
      3'h0:
      begin
        b[5:0] = ep[5:0];
        b[IRQ_BUS_RESET_BIT] = br;
        b[IRQ_SUSPEND_BIT] = sp;
      end
      3'h1:
        b[IRQ_DMA_BIT] = dm;
      // R7 endpoints three to six
      3'h2:
        b = ep[13:6];
      // R8 endpoint seven pair
      3'h3:
        b[1:0] = ep[15:14];
      default:
        b = BYTE_RESET;
    endcase
    return b;
  endfunction : irq_byte

  // R10 selection status byte
  function automatic logic [7:0] sel_byte(
    input logic full,
    input logic stall
  );
    logic [7:0] b;
    b = BYTE_RESET;
    b[SEL_FULL_BIT] = full;
    b[SEL_STALL_BIT] = stall;
    return b;
  endfunction : sel_byte

  // R16 R17 R18 buffer status byte
  function automatic logic [7:0] buf_byte(
    input logic setup,
    input logic full0,
    input logic full1,
    input logic stall
  );
    logic [7:0] b;
    b = BYTE_RESET;
    b[BUF_SETUP_BIT] = setup;
    b[BUF_FULL0_BIT] = full0;
    b[BUF_FULL1_BIT] = full1;
    b[BUF_STALL_BIT] = stall;
    return b;
  endfunction : buf_byte

  always_comb
  begin
    logic [INDEX_COUNT-1:0] ep_set;
    logic [INDEX_COUNT-1:0] ep_clr;
    logic clr_br;
    logic clr_sp;
    logic clr_dm;
    logic [2:0] limit;
    logic [2:0] prime;
    logic [2:0] cnt_inc;
    ep_set = '0;
    ep_clr = '0;
    clr_br = 1'b0;
    clr_sp = 1'b0;
    clr_dm = 1'b0;
    limit = ENHANCED ? IRQ_BYTES_ENH : IRQ_BYTES_DEF;
    prime = (s.prime4 && ENHANCED) ? IRQ_BYTES_ENH : IRQ_BYTES_DEF;
    cnt_inc = s.byte_cnt + 3'h1;
    next_s = s;
    if (XFER_DONE && xfer_index_ok)
      ep_set[XFER_INDEX] = 1'b1;
    // R21 clear only the byte handed over
    if (consume && (s.state == ST_IRQ))
    begin
      if (s.byte_cnt == 3'h0)
      begin
        // R4 bus reset clears on read
        clr_br = s.data_out[IRQ_BUS_RESET_BIT];
        // R5 suspend change clears on read
        clr_sp = s.data_out[IRQ_SUSPEND_BIT];
      end
      // R6 DMA done clears on read
      if (s.byte_cnt == 3'h1)
        clr_dm = s.data_out[IRQ_DMA_BIT];
    end
    // R3 endpoint flag cleared by status read
    if (lts_clear)
      ep_clr[s.index] = 1'b1;
    // R22 set wins over clear
    next_s.ep_flag = (s.ep_flag & ~ep_clr) | ep_set;
    next_s.bus_reset_flag = (s.bus_reset_flag && !clr_br) || BUS_RESET_SEEN;
    next_s.suspend_flag = (s.suspend_flag && !clr_sp) || susp_change;
    next_s.dma_done_flag = (s.dma_done_flag && !clr_dm) || TRANSFER_END_STROBE;
    // R5 suspend level follows detector
    next_s.suspended = susp_level;
    // R1 command aborts pending read
    if (CMD_WR)
    begin
      next_s.resume = 1'b0;
      next_s.state = ST_IDLE;
      next_s.data_valid = 1'b0;
      next_s.data_out = BYTE_RESET;
      next_s.byte_cnt = 3'h0;
      if (CMD_CODE == CMD_IRQ_READ)
      begin
        // R1 interrupt read starts at byte one
        next_s.state = ST_IRQ;
        next_s.data_valid = 1'b1;
        next_s.data_out = irq_byte(3'h0, next_s.ep_flag, next_s.bus_reset_flag,
                                   next_s.suspend_flag, next_s.dma_done_flag);
      end
      else if (CMD_CODE == CMD_BUF_IRQ_MODE)
      begin
        // R20 enable four byte prime
        if (ENHANCED)
          next_s.prime4 = 1'b1;
      end
      else if (cmd_index_ok && (CMD_CODE[7:4] == GRP_SELECT))
      begin
        // R9 select endpoint index
        next_s.sel_index = cmd_index;
        next_s.state = ST_SEL;
        next_s.data_valid = 1'b1;
        next_s.data_out = sel_byte(BUF0_FULL[cmd_index] || BUF1_FULL[cmd_index],
                                   EP_STALLED[cmd_index]);
      end
      else if (cmd_index_ok && (CMD_CODE[7:4] == GRP_LAST_STATUS))
      begin
        // R11 last status byte loaded
        next_s.index = cmd_index;
        next_s.state = ST_LTS;
        next_s.data_valid = 1'b1;
        next_s.data_out = lts_byte;
      end
      else if (cmd_index_ok && (CMD_CODE[7:4] == GRP_BUF_STATUS))
      begin
        // R16 buffer status byte loaded
        next_s.index = cmd_index;
        next_s.state = ST_BUF;
        next_s.data_valid = 1'b1;
        next_s.data_out = buf_byte(setup_bits[cmd_index], BUF0_FULL[cmd_index],
                                   BUF1_FULL[cmd_index], EP_STALLED[cmd_index]);
      end
    end
    else if (consume)
    begin
      case (s.state)
        ST_IRQ:
        begin
          next_s.byte_cnt = cnt_inc;
          // R20 prime buffer resume
          if ((cnt_inc == prime) && BUF_XFER_OPEN)
            next_s.resume = 1'b1;
          // R1 bytes in order up to limit
          if (cnt_inc >= limit)
          begin
            next_s.state = ST_IDLE;
            next_s.data_valid = 1'b0;
            next_s.data_out = BYTE_RESET;
          end
          else
            next_s.data_out = irq_byte(cnt_inc, next_s.ep_flag, next_s.bus_reset_flag,
                                       next_s.suspend_flag, next_s.dma_done_flag);
        end
        ST_SEL, ST_LTS, ST_BUF:
        begin
          next_s.state = ST_IDLE;
          next_s.data_valid = 1'b0;
          next_s.data_out = BYTE_RESET;
        end
        default:
        begin
          next_s.state = ST_IDLE;
          next_s.data_valid = 1'b0;
          next_s.data_out = BYTE_RESET;
        end
      endcase
    end
    // R19 interrupt output follows flags
    next_s.int_n = !((|next_s.ep_flag) || next_s.bus_reset_flag ||
                     next_s.suspend_flag || next_s.dma_done_flag);
  end

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      // R2 flags and outputs reset
      s <= '0;
      s.state <= ST_IDLE;
      // R19 pin idle high in reset
      s.int_n <= 1'b1;
    end
    else if (CE)
      s <= next_s;
  end

  assign DATA_OUT = s.data_out;
  assign DATA_VALID = s.data_valid;
  assign INT_N = s.int_n;
  assign SUSPENDED = s.suspended;
  assign BUF_RESUME = s.resume;

endmodule : usr_status_top

// *** sim/usr_status_assertions.sv ***
// Checker for the endpoint status reporting top
`timescale 1ns/1ps
module usr_status_assertions
  import usr_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic CE,
  // Command port
  input wire logic CMD_WR,
  input wire logic [7:0] CMD_CODE,
  input wire logic DATA_RD,
  input wire logic [7:0] DATA_OUT,
  input wire logic DATA_VALID,
  // Mode and events
  input wire logic ENHANCED,
  input wire logic XFER_DONE,
  input wire logic [3:0] XFER_INDEX,
  input wire logic BUS_RESET_SEEN,
  input wire logic TRANSFER_END_STROBE,
  // Status
  input wire logic INT_N,
  input wire logic BUF_RESUME
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);
  sequence s_lts_take;
    CE && CMD_WR && CMD_CODE[7:4] == GRP_LAST_STATUS && (ENHANCED || CMD_CODE[3:0] < 4'h6);
  endsequence
  sequence s_byte_take;
    CE && DATA_RD && !CMD_WR;
  endsequence
  a_lts_single_byte: assert property (s_lts_take ##1 s_byte_take |=> !DATA_VALID)
    else $error("status read offered a second byte");
  a_irq_answer: assert property (CE && CMD_WR && CMD_CODE == CMD_IRQ_READ |=> DATA_VALID)
    else $error("interrupt read gave no byte");
  sequence s_sel_bad;
    CE && CMD_WR && CMD_CODE[7:4] == GRP_SELECT && !ENHANCED && CMD_CODE[3:0] >= 4'h6;
  endsequence
  sequence s_byte_idle;
    DATA_VALID && !(CE && (CMD_WR || DATA_RD));
  endsequence
  a_sel_refused: assert property (s_sel_bad |=> !DATA_VALID)
    else $error("bad select index answered");
  a_byte_stands: assert property (s_byte_idle |=> DATA_VALID && $stable(DATA_OUT))
    else $error("offered byte changed");
  a_idle_zero: assert property (!DATA_VALID |-> DATA_OUT == BYTE_RESET)
    else $error("idle data not zero");
  a_xfer_int: assert property (CE && XFER_DONE && (ENHANCED || XFER_INDEX < 4'h6) |=> !INT_N)
    else $error("endpoint event left interrupt high");
  a_bus_reset_int: assert property (CE && BUS_RESET_SEEN |=> !INT_N)
    else $error("bus reset left interrupt high");
  a_dma_done_int: assert property (CE && TRANSFER_END_STROBE |=> !INT_N)
    else $error("dma end left interrupt high");
  a_resume_drop: assert property (CE && CMD_WR |=> !BUF_RESUME)
    else $error("resume kept over a command");
  a_resume_hold: assert property (BUF_RESUME && !(CE && CMD_WR) |=> BUF_RESUME)
    else $error("resume lost without a command");
  a_reset_clean: assert property ($rose(RSTN) |-> INT_N && !DATA_VALID && !BUF_RESUME)
    else $error("outputs not idle after reset");
endmodule : usr_status_assertions

bind usr_status_top usr_status_assertions i_chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .CE(CE),
  .CMD_WR(CMD_WR), .CMD_CODE(CMD_CODE), .DATA_RD(DATA_RD), .DATA_OUT(DATA_OUT),
  .DATA_VALID(DATA_VALID), .ENHANCED(ENHANCED), .XFER_DONE(XFER_DONE),
  .XFER_INDEX(XFER_INDEX), .BUS_RESET_SEEN(BUS_RESET_SEEN),
  .TRANSFER_END_STROBE(TRANSFER_END_STROBE), .INT_N(INT_N), .BUF_RESUME(BUF_RESUME));

// *** sim/usr_host_model.sv ***
// Microcontroller model driving the command port
`timescale 1ns/1ps
module usr_host_model
(
  // Clock
  input wire logic REF_CLK,
  // Command port
  output logic CMD_WR,
  output logic [7:0] CMD_CODE,
  output logic DATA_RD,
  input wire logic [7:0] DATA_OUT,
  input wire logic DATA_VALID
);
  initial
  begin
    CMD_WR = 1'b0;
    CMD_CODE = 8'h00;
    DATA_RD = 1'b0;
  end
  task cmd(input logic [7:0] c);
    @(negedge REF_CLK);
    CMD_WR = 1'b1;
    CMD_CODE = c;
    @(negedge REF_CLK);
    CMD_WR = 1'b0;
    CMD_CODE = ~c;
  endtask : cmd
  task rd(output logic [7:0] b);
    b = DATA_OUT;
    DATA_RD = 1'b1;
    @(negedge REF_CLK);
    DATA_RD = 1'b0;
    @(negedge REF_CLK);
  endtask : rd
endmodule : usr_host_model

// *** sim/tb_top.sv ***
// Self-checking bench for the endpoint status reporting block
`timescale 1ns/1ps
module tb_top;
  import usr_pkg::*;
  logic ref_clk, rstn, enh, xfer_done, bus_rst, sof, tick, dma_end, buf_open;
  logic [3:0] xfer_index;
  logic [6:0] xfer_status;
  logic [15:0] buf0, buf1, stall;
  logic cmd_wr, data_rd, data_valid, int_n, suspended, buf_resume, ce;
  logic [7:0] cmd_code, data_out;
  logic [3:0] errs [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha,
    4'hb, 4'hd, 4'hf};
  int err_count = 0;
  int samples_checked = 0;

  usr_host_model i_host (.REF_CLK(ref_clk), .CMD_WR(cmd_wr), .CMD_CODE(cmd_code),
    .DATA_RD(data_rd), .DATA_OUT(data_out), .DATA_VALID(data_valid));
  usr_status_top #(.INDEX_COUNT(16)) i_dut (.REF_CLK(ref_clk), .RSTN(rstn), .CE(ce),
    .CMD_WR(cmd_wr), .CMD_CODE(cmd_code), .DATA_RD(data_rd), .DATA_OUT(data_out),
    .DATA_VALID(data_valid), .ENHANCED(enh), .XFER_DONE(xfer_done),
    .XFER_INDEX(xfer_index), .XFER_STATUS(xfer_status), .BUS_RESET_SEEN(bus_rst),
    .SOF_SEEN(sof), .FRAME_TICK(tick), .TRANSFER_END_STROBE(dma_end), .BUF0_FULL(buf0),
    .BUF1_FULL(buf1), .EP_STALLED(stall), .BUF_XFER_OPEN(buf_open), .INT_N(int_n),
    .SUSPENDED(suspended), .BUF_RESUME(buf_resume));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task wrap_up;
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task irq(input int n, input logic [31:0] e);
    logic [7:0] b;
    i_host.cmd(CMD_IRQ_READ);
    for (int k = 0; k < n; k++)
    begin
      i_host.rd(b);
      chk("irq byte", e[8*k+:8], b);
    end
  endtask : irq

  task one(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] b;
    i_host.cmd(c);
    i_host.rd(b);
    chk("status byte", e, b);
    chk("valid", 8'h00, {7'h0, data_valid});
  endtask : one

  task ev(input logic [3:0] i, input logic [6:0] s);
    @(negedge ref_clk);
    xfer_done = 1'b1;
    xfer_index = i;
    xfer_status = s;
    @(negedge ref_clk);
    xfer_done = 1'b0;
  endtask : ev

  task tk;
    @(negedge ref_clk);
    tick = 1'b1;
    @(negedge ref_clk);
    tick = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask : tk

  initial
  begin
    #200us;
    err_count++;
    wrap_up;
  end

  initial
  begin
    logic [6:0] s;
    logic [7:0] b;
    {rstn, xfer_done, bus_rst, sof, tick, dma_end, buf_open} = 7'h00;
    {xfer_index, xfer_status} = 11'h000;
    enh = 1'b1;
    ce = 1'b1;
    buf0 = 16'h00f0;
    buf1 = 16'h0f00;
    stall = 16'h3003;
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    chk("int_n", 8'h01, {7'h0, int_n});
    irq(4, 32'h0);
    chk("valid", 8'h00, {7'h0, data_valid});
    for (int i = 0; i < 16; i++)
      ev(4'(i), {i[0], i[1], errs[i % 13], i % 13 == 0});
    ev(4'h2, 7'h55);
    chk("int_n", 8'h00, {7'h0, int_n});
    irq(4, 32'h03ff003f);
    for (int i = 0; i < 16; i++)
    begin
      s = (i == 2) ? 7'h55 : {i[0], i[1], errs[i % 13], i % 13 == 0};
      one(8'(i), {6'h0, stall[i], buf0[i] | buf1[i]});
      one(8'h80 + 8'(i), {stall[i], buf1[i], buf0[i], 2'h0, s[5], 2'h0});
      one(8'h40 + 8'(i), {i == 2, s});
    end
    chk("int_n", 8'h01, {7'h0, int_n});
    irq(1, 32'h0);
    @(negedge ref_clk);
    bus_rst = 1'b1;
    dma_end = 1'b1;
    @(negedge ref_clk);
    bus_rst = 1'b0;
    dma_end = 1'b0;
    irq(1, 32'h40);
    irq(2, 32'h0100);
    irq(2, 32'h0);
    @(negedge ref_clk);
    dma_end = 1'b1;
    @(negedge ref_clk);
    dma_end = 1'b0;
    irq(1, 32'h0);
    dma_end = 1'b1;
    fork
      i_host.rd(b);
      @(negedge ref_clk) dma_end = 1'b0;
    join
    chk("dma byte", 8'h01, b);
    irq(2, 32'h0100);
    chk("int_n", 8'h01, {7'h0, int_n});
    @(negedge ref_clk);
    sof = 1'b1;
    @(negedge ref_clk);
    sof = 1'b0;
    repeat (3) tk;
    chk("suspended", 8'h00, {7'h0, suspended});
    tk;
    chk("suspended", 8'h01, {7'h0, suspended});
    irq(1, 32'h80);
    sof = 1'b1;
    @(negedge ref_clk);
    sof = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("suspended", 8'h00, {7'h0, suspended});
    irq(1, 32'h80);
    chk("int_n", 8'h01, {7'h0, int_n});
    buf_open = 1'b1;
    enh = 1'b0;
    i_host.cmd(8'h06);
    chk("valid", 8'h00, {7'h0, data_valid});
    i_host.cmd(8'h46);
    chk("valid", 8'h00, {7'h0, data_valid});
    one(8'h85, 8'h20);
    irq(2, 32'h0);
    chk("valid", 8'h00, {7'h0, data_valid});
    chk("resume", 8'h01, {7'h0, buf_resume});
    enh = 1'b1;
    i_host.cmd(CMD_BUF_IRQ_MODE);
    chk("resume", 8'h00, {7'h0, buf_resume});
    irq(2, 32'h0);
    chk("resume", 8'h00, {7'h0, buf_resume});
    i_host.rd(b);
    i_host.rd(b);
    chk("resume", 8'h01, {7'h0, buf_resume});
    ce = 1'b0;
    dma_end = 1'b1;
    @(negedge ref_clk);
    dma_end = 1'b0;
    ce = 1'b1;
    chk("int_n", 8'h01, {7'h0, int_n});
    chk("resume", 8'h01, {7'h0, buf_resume});
    wrap_up;
  end
endmodule : tb_top
